// file: logic/drv_prot_pkg.sv
package drv_prot_pkg;
   // timing
   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned TIMEOUT_US     = 1000;
   localparam int unsigned TIMEOUT_CYC    = TIMEOUT_US * CLK_MHZ;
   localparam int unsigned BLANK_NS       = 2500;
   localparam int unsigned BLANK_CYC      = (BLANK_NS * CLK_MHZ + 999) / 1000;

   // command word: [15:12] opcode, [11:1] payload, [0] odd parity
   localparam int unsigned CMD_W          = 16;
   localparam int unsigned OP_LSB         = 12;
   localparam int unsigned PL_LSB         = 1;
   localparam logic [3:0]  OP_MODE        = 4'h1;
   localparam logic [3:0]  OP_SELFTEST    = 4'h2;
   localparam logic [3:0]  OP_CTRL        = 4'h3;
   localparam logic [3:0]  OP_CFG         = 4'h4;
   localparam logic [3:0]  OP_CLEAR       = 4'h5;
   localparam logic [3:0]  OP_READ        = 4'h6;
   localparam logic [3:0]  OP_UNLOCK      = 4'h7;
   localparam logic [10:0] UNLOCK_KEY_A   = 11'h2A5;
   localparam logic [10:0] UNLOCK_KEY_B   = 11'h15A;

   // payload fields
   localparam int unsigned ST_COLLECTOR_SATURATION_LOSS_L1    = 0;
   localparam int unsigned ST_COLLECTOR_SATURATION_LOSS_L2    = 1;
   localparam int unsigned CFG_BOOST_COMP = 0;
   localparam int unsigned CFG_PAR_DIS    = 1;
   localparam int unsigned CFG_TWO_LEVEL_TURNOFF_EN   = 2;
   localparam int unsigned CFG_PLAT_LSB   = 3;

   // primary error register bits
   localparam int unsigned ERR_OVERHEAT   = 0;
   localparam int unsigned ERR_SERIAL     = 1;
   localparam int unsigned ERR_COLLECTOR_SATURATION_LOSS      = 2;
   localparam int unsigned ERR_W          = 3;

   // gate voltage codes and reset values
   localparam logic [4:0]  FULL_ON_LEVEL  = 5'h1F;
   localparam logic [4:0]  VBE_STEP       = 5'h02;
   localparam logic [4:0]  RST_WEAK_ON    = 5'h00;
   localparam logic [3:0]  RST_PLATEAU    = 4'h0;

   typedef enum logic [2:0] {
      default_mode       = 3'h0,
      configuration_mode = 3'h1,
      active_mode        = 3'h3,
      verification_mode  = 3'h2,
      weak_active_mode   = 3'h6
   } mode_e;

   function automatic logic odd_parity(input logic [CMD_W-1:1] body);
      odd_parity = ~(^body);
   endfunction : odd_parity
endpackage : drv_prot_pkg

// file: logic/drv_prot_if.sv
interface drv_prot_if;
   import drv_prot_pkg::*;
   logic             cmd_valid;
   logic [CMD_W-1:0] cmd_word;
   logic             rsp_valid;
   logic [CMD_W-1:0] rsp_word;
   logic             pwm;
   logic             sf_oe;
   wire              sf_level;
   // open drain with pull-up: low only while the device drives
   assign sf_level = ~sf_oe;

   modport device_end (input cmd_valid, cmd_word, pwm, output rsp_valid, rsp_word, sf_oe);
   modport host_end   (output cmd_valid, cmd_word, pwm, input rsp_valid, rsp_word, sf_level);
endinterface : drv_prot_if

// file: logic/drv_prot_device.sv
module drv_prot_device
   import drv_prot_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int unsigned TEMP_W         = 10,
   parameter int unsigned OT_LIMIT       = 768
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              ce,
   // link to the controller
   drv_prot_if.device_end         link,
   // analog side status
   input  wire logic [TEMP_W-1:0] temp_reading,
   input  wire logic              gate_supply_undervoltage,
   input  wire logic              digital_supply_ok,
   input  wire logic              collector_saturation_loss_comp_above,
   // gate side controls
   output logic                   gate_drive_on_pin,
   output logic [4:0]             gate_on_level,
   output logic                   reduced_gate_probe,
   output logic                   collector_saturation_loss_force,
   output logic                   high_gate_mon_en,
   output logic                   out_stage_mon_en,
   output logic [2:0]             mode_state,
   output logic [ERR_W-1:0]       primary_error_reg
);
   localparam int unsigned TMO_W = $clog2(TIMEOUT_CYCLES + 1);
   localparam int unsigned BLK_W = $clog2(BLANK_CYC + 1);

   if (TIMEOUT_CYCLES < 2 || TEMP_W < 1 || OT_LIMIT >= (1 << TEMP_W)) begin : g_bad_param
      $error("drv_prot_device: unusable parameter value");
   end

   mode_e            mode_q, mode_d;
   logic [1:0]       unlock_q, unlock_d;
   logic [1:0]       sh_sel_q, act_sel_q;
   logic [4:0]       weak_on_q;
   logic             comp_q, par_dis_q;
   logic [ERR_W-1:0] err_q, err_d;
   logic [TMO_W-1:0] tmo_q;
   logic [BLK_W-1:0] blk_q;
   logic             rsp_valid_q;
   logic [CMD_W-1:0] rsp_word_q;
   logic             sf_oe_q;

   // command decode
   wire logic [3:0]  op        = link.cmd_word[CMD_W-1:OP_LSB];
   wire logic [10:0] pl        = link.cmd_word[OP_LSB-1:PL_LSB];
   wire logic        take      = ce & link.cmd_valid;
   wire logic        par_ok    = par_dis_q | (link.cmd_word[0] == odd_parity(link.cmd_word[CMD_W-1:1]));
   wire logic        op_known  = (op >= OP_MODE) && (op <= OP_UNLOCK);
   wire logic        mode_code = pl[2:0] inside {default_mode, configuration_mode, active_mode,
                                                 verification_mode, weak_active_mode};
   wire logic        cmd_bad   = take & (~par_ok | ~op_known | (op == OP_MODE & ~mode_code));
   wire logic        cmd_ok    = take & ~cmd_bad;
   wire logic        in_cfg    = mode_q == configuration_mode;
   wire logic        in_test   = (mode_q == verification_mode) | (mode_q == weak_active_mode);
   wire logic        in_weak   = mode_q == weak_active_mode;
   wire logic        in_active = mode_q == active_mode;
   wire logic        unlocked  = unlock_q == 2'd2;
   wire logic        timed_out = in_test & (tmo_q == TMO_W'(TIMEOUT_CYCLES - 1));

   // mode transition table; refused requests leave the mode unchanged
   function automatic mode_e next_mode(input mode_e cur, input logic [2:0] tgt, input logic unl);
      next_mode = cur;
      unique case (tgt)
         default_mode:       next_mode = default_mode;
         configuration_mode: if (cur == default_mode) next_mode = configuration_mode;
         active_mode:        if (cur == configuration_mode) next_mode = active_mode;
         // from configuration once unlocked, or back from weak active mode without the unlock; never from active
         verification_mode:  if ((cur == configuration_mode && unl) || cur == weak_active_mode) begin
            next_mode = verification_mode;
         end
         weak_active_mode:   if (cur == verification_mode) next_mode = weak_active_mode;
         default:            next_mode = cur;
      endcase
   endfunction : next_mode

   always_comb begin
      mode_d = mode_q;
      if (timed_out) begin
         mode_d = default_mode;
      end else if (cmd_ok && op == OP_MODE) begin
         mode_d = next_mode(mode_q, pl[2:0], unlocked);
      end
   end

   // unlock: key A then key B back to back, any other accepted command restarts
   always_comb begin
      unlock_d = unlock_q;
      if (cmd_ok && !unlocked) begin
         if (op == OP_UNLOCK && pl == UNLOCK_KEY_A) begin
            unlock_d = 2'd1;
         end else if (op == OP_UNLOCK && pl == UNLOCK_KEY_B && unlock_q == 2'd1) begin
            unlock_d = 2'd2;
         end else begin
            unlock_d = 2'd0;
         end
      end
   end

   // selected test level, valid only inside the test modes
   wire logic lvl1 = in_test & act_sel_q[ST_COLLECTOR_SATURATION_LOSS_L1];
   wire logic lvl2 = in_test & act_sel_q[ST_COLLECTOR_SATURATION_LOSS_L2] & ~act_sel_q[ST_COLLECTOR_SATURATION_LOSS_L1];

   // gate drive: stopped by a latched saturation error until software clears it
   wire logic gate_allowed = in_active | (in_weak & ~lvl2);
   wire logic drive_d      = link.pwm & gate_allowed & ~err_q[ERR_COLLECTOR_SATURATION_LOSS];
   // saturation detection runs for any turn-on command in active or weak active mode, even when level 2 holds the gate off
   wire logic sat_watch    = link.pwm & (in_active | in_weak) & ~err_q[ERR_COLLECTOR_SATURATION_LOSS];
   wire logic blank_done   = blk_q == BLK_W'(BLANK_CYC);
   wire logic collector_saturation_loss_hit    = sat_watch & blank_done & (collector_saturation_loss_comp_above | lvl1);

   // probe level: one diode drop lower with booster compensation, floored at zero
   wire logic [4:0] comp_level  = (weak_on_q > VBE_STEP) ? (weak_on_q - VBE_STEP) : 5'h00;
   wire logic [4:0] probe_level = comp_q ? comp_level : weak_on_q;
   wire logic [4:0] level_d     = in_weak ? probe_level : FULL_ON_LEVEL;

   wire logic [ERR_W-1:0] err_set;
   assign err_set[ERR_OVERHEAT] = temp_reading > TEMP_W'(OT_LIMIT);
   assign err_set[ERR_SERIAL]   = cmd_bad;
   assign err_set[ERR_COLLECTOR_SATURATION_LOSS]    = collector_saturation_loss_hit;
   wire logic [ERR_W-1:0] err_clr = (cmd_ok && op == OP_CLEAR) ? pl[ERR_W-1:0] : '0;
   // a new event in the clearing cycle survives
   assign err_d = (err_q & ~err_clr) | err_set;

   wire logic [CMD_W-1:0] status_word = {mode_q, unlocked, act_sel_q, sh_sel_q, comp_q, par_dis_q,
                                         3'b000, err_q};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= default_mode;
         unlock_q <= 2'd0;
         err_q <= '0;
      end else if (ce) begin
         mode_q <= mode_d;
         unlock_q <= unlock_d;
         err_q <= err_d;
      end
   end

   // configuration writes are taken in configuration mode only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sh_sel_q <= 2'b00;
         weak_on_q <= RST_WEAK_ON;
         comp_q <= 1'b0;
         par_dis_q <= 1'b0;
      end else if (ce && cmd_ok && in_cfg) begin
         if (op == OP_SELFTEST) sh_sel_q <= pl[1:0];
         if (op == OP_CTRL) weak_on_q <= pl[4:0];
         if (op == OP_CFG) begin
            comp_q <= pl[CFG_BOOST_COMP];
            par_dis_q <= pl[CFG_PAR_DIS];
         end
      end
   end

   // test selections take effect only when verification mode is entered
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         act_sel_q <= 2'b00;
      end else if (ce) begin
         if (mode_d == verification_mode && in_cfg) act_sel_q <= sh_sel_q;
         else if (!(mode_d == verification_mode || mode_d == weak_active_mode)) act_sel_q <= 2'b00;
      end
   end

   // timeout spans the whole stay in the two test modes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tmo_q <= '0;
      end else if (ce) begin
         tmo_q <= in_test ? tmo_q + 1'b1 : '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         blk_q <= '0;
      end else if (ce) begin
         if (!sat_watch) blk_q <= '0;
         else if (!blank_done) blk_q <= blk_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_valid_q <= 1'b0;
         rsp_word_q <= '0;
      end else if (ce) begin
         rsp_valid_q <= cmd_ok & (op == OP_READ);
         if (cmd_ok && op == OP_READ) rsp_word_q <= status_word;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gate_drive_on_pin <= 1'b0;
         gate_on_level <= FULL_ON_LEVEL;
         reduced_gate_probe <= 1'b0;
         collector_saturation_loss_force <= 1'b0;
         high_gate_mon_en <= 1'b1;
         out_stage_mon_en <= 1'b1;
         sf_oe_q <= 1'b0;
      end else if (ce) begin
         gate_drive_on_pin <= drive_d;
         gate_on_level <= level_d;
         reduced_gate_probe <= mode_d == weak_active_mode;
         collector_saturation_loss_force <= lvl1;
         high_gate_mon_en <= ~(mode_d inside {verification_mode, weak_active_mode});
         out_stage_mon_en <= ~(mode_d inside {verification_mode, weak_active_mode});
         sf_oe_q <= gate_supply_undervoltage | ~digital_supply_ok;
      end
   end

   assign mode_state = mode_q;
   assign primary_error_reg = err_q;
   assign link.rsp_valid = rsp_valid_q;
   assign link.rsp_word = rsp_word_q;
   assign link.sf_oe = sf_oe_q;
endmodule : drv_prot_device

// file: logic/drv_prot_host.sv
module drv_prot_host
   import drv_prot_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   // link to the driver
   drv_prot_if.host_end     link,
   // user requests
   input  wire logic        req_valid,
   input  wire logic [3:0]  req_op,
   input  wire logic [10:0] req_payload,
   input  wire logic        req_bad_parity,
   output logic             req_ready,
   output logic             req_refused,
   // answers and status
   output logic             rsp_valid,
   output logic [15:0]      rsp_data,
   input  wire logic        pwm_in,
   output logic             supply_fault_seen
);
   logic [3:0]       plateau_q;
   logic             two_level_turnoff_q;
   logic [4:0]       weak_on_q;
   logic             cmd_valid_q;
   logic [CMD_W-1:0] cmd_word_q;
   logic             pwm_q;

   wire logic take = ce & req_valid & req_ready;
   wire logic to_test = req_op == OP_MODE &&
                        (req_payload[2:0] == verification_mode || req_payload[2:0] == weak_active_mode);
   // policy checks guard the device against unsafe but legal settings
   wire logic multi_sel = req_op == OP_SELFTEST && req_payload[ST_COLLECTOR_SATURATION_LOSS_L1] && req_payload[ST_COLLECTOR_SATURATION_LOSS_L2];
   wire logic plat_set  = to_test && plateau_q != RST_PLATEAU;
   // both orders of programming are caught: a low probe level, or a high plateau after the probe level
   wire logic plat_high = (req_op == OP_CTRL && two_level_turnoff_q && {1'b0, plateau_q} >= req_payload[4:0]) ||
                          (req_op == OP_CFG && req_payload[CFG_TWO_LEVEL_TURNOFF_EN] &&
                           {1'b0, req_payload[CFG_PLAT_LSB +: 4]} >= weak_on_q);
   wire logic refuse    = multi_sel | plat_set | plat_high;
   wire logic [CMD_W-1:1] body = {req_op, req_payload};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         plateau_q <= RST_PLATEAU;
         two_level_turnoff_q <= 1'b0;
         weak_on_q <= RST_WEAK_ON;
      end else if (take && !refuse) begin
         if (req_op == OP_CFG) begin
            plateau_q <= req_payload[CFG_PLAT_LSB +: 4];
            two_level_turnoff_q <= req_payload[CFG_TWO_LEVEL_TURNOFF_EN];
         end
         if (req_op == OP_CTRL) weak_on_q <= req_payload[4:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         req_ready <= 1'b0;
         req_refused <= 1'b0;
         cmd_valid_q <= 1'b0;
         cmd_word_q <= '0;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         pwm_q <= 1'b0;
         supply_fault_seen <= 1'b0;
      end else if (ce) begin
         req_ready <= 1'b1;
         req_refused <= take & refuse;
         cmd_valid_q <= take & ~refuse;
         if (take && !refuse) cmd_word_q <= {body, odd_parity(body) ^ req_bad_parity};
         rsp_valid <= link.rsp_valid;
         if (link.rsp_valid) rsp_data <= link.rsp_word;
         pwm_q <= pwm_in;
         supply_fault_seen <= ~link.sf_level;
      end
   end

   assign link.cmd_valid = cmd_valid_q;
   assign link.cmd_word = cmd_word_q;
   assign link.pwm = pwm_q;
endmodule : drv_prot_host

// file: bench/drv_prot_chk.sv
module drv_prot_chk
   import drv_prot_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   // clock and reset
   input wire logic               clk,
   input wire logic               rst_b,
   // link signals
   input wire logic               cmd_valid,
   input wire logic [CMD_W-1:0]   cmd_word,
   input wire logic               rsp_valid,
   input wire logic               sf_oe,
   // device status
   input wire logic               gate_supply_undervoltage,
   input wire logic               digital_supply_ok,
   input wire logic               gate_drive_on_pin,
   input wire logic               reduced_gate_probe,
   input wire logic               high_gate_mon_en,
   input wire logic               out_stage_mon_en,
   input wire logic [2:0]         mode_state,
   input wire logic [ERR_W-1:0]   primary_error_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic [31:0] test_cyc_q;
   logic [31:0] test_cyc_d;
   logic        key_seen_q;
   logic        key_seen_d;
   wire         in_test  = (mode_state == verification_mode) || (mode_state == weak_active_mode);
   wire         key_b_in = cmd_valid && (cmd_word[15:1] == {OP_UNLOCK, UNLOCK_KEY_B});

   // time spent in the test modes, since the bound is shared by both of them
   assign test_cyc_d = in_test ? test_cyc_q + 32'h0000_0001 : 32'h0000_0000;
   assign key_seen_d = key_seen_q | key_b_in;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         test_cyc_q <= 32'h0000_0000;
         key_seen_q <= 1'b0;
      end else begin
         test_cyc_q <= test_cyc_d;
         key_seen_q <= key_seen_d;
      end
   end

   sequence s_read_cmd;
      cmd_valid && (cmd_word[15:12] == OP_READ) && (^cmd_word);
   endsequence
   sequence s_rsp_pulse;
      rsp_valid ##1 !rsp_valid;
   endsequence
   sequence s_collector_saturation_loss_rise;
      $rose(primary_error_reg[ERR_COLLECTOR_SATURATION_LOSS]);
   endsequence

   AST_READ_PULSE: assert property (s_read_cmd |=> s_rsp_pulse)
      else $error("read answer is not a single pulse");
   AST_BAD_OPCODE: assert property (cmd_valid && ((cmd_word[15:12] == 4'h0) || cmd_word[15])
      |=> primary_error_reg[ERR_SERIAL])
      else $error("undefined opcode left serial fault clear");
   AST_STICKY: assert property (|(~primary_error_reg & $past(primary_error_reg))
      |-> $past(cmd_valid && (cmd_word[15:12] == OP_CLEAR)))
      else $error("error flag dropped without a clear command");
   AST_SUPPLY_PIN: assert property (sf_oe == $past(gate_supply_undervoltage || !digital_supply_ok))
      else $error("supply fault pin does not follow supply state");
   AST_UNLOCK: assert property (mode_state == verification_mode |-> key_seen_q)
      else $error("verification entered without unlock");
   AST_NO_TEST_FROM_ACTIVE: assert property ($past(mode_state) == active_mode
      |-> !in_test)
      else $error("test mode entered from active mode");
   AST_TIMEOUT: assert property (in_test |-> test_cyc_q < TIMEOUT_CYCLES)
      else $error("test mode outlived its timeout");
   AST_MON_OFF: assert property (in_test |-> !high_gate_mon_en && !out_stage_mon_en)
      else $error("monitors left on in test mode");
   AST_PROBE_MODE: assert property (reduced_gate_probe == (mode_state == weak_active_mode))
      else $error("probe turn-on does not match weak active mode");
   AST_COLLECTOR_SATURATION_LOSS_GATE_OFF: assert property (s_collector_saturation_loss_rise |=> !gate_drive_on_pin)
      else $error("gate still on after saturation error");
endmodule : drv_prot_chk

// file: bench/test_driver_protection_verification.sv
module test_driver_protection_verification
   import drv_prot_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned TMO = 1024;
   typedef struct packed {
      logic [3:0]  op;
      logic [10:0] pl;
      logic        bad;
      logic [2:0]  mode;
      logic [2:0]  err;
   } row_s;
   logic clk, rst_b, gate_supply_undervoltage, digital_supply_ok, collector_saturation_loss_comp_above, pwm_in;
   logic req_valid, req_bad_parity, req_ready, supply_fault_seen, gate_drive_on_pin;
   logic reduced_gate_probe, collector_saturation_loss_force, high_gate_mon_en, out_stage_mon_en;
   logic dev_ce, req_refused, rsp_valid;
   logic [15:0]      rsp_data;
   logic [3:0]       req_op;
   logic [10:0]      req_payload;
   logic [9:0]       temp_reading;
   logic [4:0]       gate_on_level;
   logic [2:0]       mode_state;
   logic [ERR_W-1:0] primary_error_reg;
   int               fail_count = 0;
   int               checks = 0;
   int               cyc = 0;
   int               refused_cnt = 0;
   int               rsp_cnt = 0;
   row_s             rows [16] = '{
      '{OP_MODE, 11'h001, 1'b0, 3'h1, 3'h0}, '{OP_MODE, 11'h001, 1'b1, 3'h1, 3'h2},
      '{OP_CLEAR, 11'h002, 1'b0, 3'h1, 3'h0}, '{OP_CFG, 11'h002, 1'b0, 3'h1, 3'h0},
      '{OP_READ, 11'h000, 1'b1, 3'h1, 3'h0}, '{4'h0, 11'h000, 1'b0, 3'h1, 3'h2},
      '{OP_CLEAR, 11'h007, 1'b0, 3'h1, 3'h0}, '{OP_CFG, 11'h000, 1'b0, 3'h1, 3'h0},
      '{OP_MODE, 11'h002, 1'b0, 3'h1, 3'h0}, '{OP_UNLOCK, UNLOCK_KEY_A, 1'b0, 3'h1, 3'h0},
      '{OP_UNLOCK, UNLOCK_KEY_B, 1'b0, 3'h1, 3'h0}, '{OP_SELFTEST, 11'h001, 1'b0, 3'h1, 3'h0},
      '{OP_CTRL, 11'h00A, 1'b0, 3'h1, 3'h0}, '{OP_CFG, 11'h001, 1'b0, 3'h1, 3'h0},
      '{OP_MODE, 11'h002, 1'b0, 3'h2, 3'h0}, '{OP_MODE, 11'h006, 1'b0, 3'h6, 3'h0}};

   drv_prot_if link ();
   drv_prot_device #(.TIMEOUT_CYCLES(TMO)) u_drv_prot_device (.clk, .rst_b, .ce(dev_ce), .link(link),
      .temp_reading, .gate_supply_undervoltage, .digital_supply_ok, .collector_saturation_loss_comp_above, .gate_drive_on_pin,
      .gate_on_level, .reduced_gate_probe, .collector_saturation_loss_force, .high_gate_mon_en, .out_stage_mon_en,
      .mode_state, .primary_error_reg);
   drv_prot_host u_drv_prot_host (.clk, .rst_b, .ce(1'b1), .link(link), .req_valid, .req_op, .req_payload,
      .req_bad_parity, .req_ready, .req_refused, .rsp_valid, .rsp_data, .pwm_in, .supply_fault_seen);
   drv_prot_chk #(.TIMEOUT_CYCLES(TMO)) u_chk (.clk, .rst_b, .cmd_valid(link.cmd_valid),
      .cmd_word(link.cmd_word), .rsp_valid(link.rsp_valid), .sf_oe(link.sf_oe), .gate_supply_undervoltage,
      .digital_supply_ok, .gate_drive_on_pin, .reduced_gate_probe, .high_gate_mon_en, .out_stage_mon_en,
      .mode_state, .primary_error_reg);

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc

   // one request, then enough edges for the device's effect to land
   task automatic send(input logic [3:0] op, input logic [10:0] pl, input logic bad);
      @(posedge clk);
      while (req_ready !== 1'b1) @(posedge clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_payload <= pl;
      req_bad_parity <= bad;
      @(posedge clk);
      req_valid <= 1'b0;
      wait_cyc(3);
   endtask : send

   task automatic end_sim();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ceiling well above the roughly 2300 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (req_refused === 1'b1) refused_cnt++;
      if (rsp_valid === 1'b1) rsp_cnt++;
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   initial begin
      rst_b = 1'b0;
      {gate_supply_undervoltage, collector_saturation_loss_comp_above, pwm_in, req_valid, req_bad_parity} = 5'h00;
      digital_supply_ok = 1'b1;
      dev_ce = 1'b1;
      req_op = 4'h0;
      req_payload = 11'h000;
      temp_reading = 10'h000;
      wait_cyc(8);
      chk("reset level", 16'h001F, 16'(gate_on_level));
      chk("reset state", 16'h0003, 16'({mode_state, primary_error_reg, high_gate_mon_en, out_stage_mon_en}));
      @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         send(rows[i].op, rows[i].pl, rows[i].bad);
         chk("mode", 16'(rows[i].mode), 16'(mode_state));
         chk("error", 16'(rows[i].err), 16'(primary_error_reg));
      end
      chk("refusals", 16'h0000, 16'(refused_cnt));
      chk("probe", 16'h0001, 16'(reduced_gate_probe));
      chk("monitors", 16'h0000, 16'({high_gate_mon_en, out_stage_mon_en}));
      chk("level", 16'h0008, 16'(gate_on_level));
      chk("force", 16'h0001, 16'(collector_saturation_loss_force));
      @(posedge clk);
      pwm_in <= 1'b1;
      wait_cyc(4);
      chk("gate", 16'h0001, 16'(gate_drive_on_pin));
      wait_cyc(BLANK_CYC + 4);
      chk("error", 16'h0004, 16'(primary_error_reg));
      chk("gate", 16'h0000, 16'(gate_drive_on_pin));
      @(posedge clk);
      pwm_in <= 1'b0;
      send(OP_CLEAR, 11'h004, 1'b0);
      chk("error", 16'h0000, 16'(primary_error_reg));
      for (int m = 0; m < 5; m++) send(OP_MODE, 11'(m == 2 ? 3 : m == 3 ? 2 : m == 4 ? 6 : m), 1'b0);
      chk("mode", 16'h0003, 16'(mode_state));
      send(OP_MODE, 11'h000, 1'b0);
      send(OP_MODE, 11'h001, 1'b0);
      send(OP_SELFTEST, 11'h002, 1'b0);
      send(OP_CFG, 11'h000, 1'b0);
      send(OP_MODE, 11'h002, 1'b0);
      send(OP_MODE, 11'h006, 1'b0);
      @(posedge clk);
      pwm_in <= 1'b1;
      collector_saturation_loss_comp_above <= 1'b1;
      wait_cyc(4);
      chk("gate", 16'h0000, 16'(gate_drive_on_pin));
      chk("level", 16'h000A, 16'(gate_on_level));
      wait_cyc(BLANK_CYC + 4);
      chk("error", 16'h0004, 16'(primary_error_reg));
      wait_cyc(TMO);
      chk("mode", 16'h0000, 16'(mode_state));
      @(posedge clk);
      pwm_in <= 1'b0;
      collector_saturation_loss_comp_above <= 1'b0;
      send(OP_CLEAR, 11'h007, 1'b0);
      for (int t = 0; t < 3; t++) begin
         @(posedge clk);
         temp_reading <= (t == 1) ? 10'h301 : (t == 0) ? 10'h300 : 10'h000;
         wait_cyc(3);
         chk("overheat", (t == 0) ? 16'h0000 : 16'h0001, 16'(primary_error_reg));
      end
      for (int s = 0; s < 3; s++) begin
         @(posedge clk);
         gate_supply_undervoltage <= (s == 0);
         digital_supply_ok <= (s != 1);
         wait_cyc(3);
         chk("fault pin", 16'(s == 2), 16'(link.sf_level));
         chk("fault seen", 16'(s != 2), 16'(supply_fault_seen));
      end
      // policy refusals stay on the host; only the first, safe setting goes out
      send(OP_CFG, 11'h00C, 1'b0);
      send(OP_MODE, 11'h002, 1'b0);
      send(OP_CTRL, 11'h001, 1'b0);
      send(OP_CFG, 11'h05C, 1'b0);
      send(OP_SELFTEST, 11'h003, 1'b0);
      chk("refusals", 16'h0004, 16'(refused_cnt));
      // a command that arrives while the device's enable is low is lost
      @(posedge clk);
      dev_ce <= 1'b0;
      send(OP_MODE, 11'h001, 1'b0);
      chk("frozen mode", 16'h0000, 16'(mode_state));
      @(posedge clk);
      dev_ce <= 1'b1;
      send(OP_READ, 11'h000, 1'b0);
      chk("status", 16'h1201, rsp_data);
      chk("answers", 16'h0002, 16'(rsp_cnt));
      // a second reset must drop the unlock, so verification is refused again
      @(posedge clk);
      rst_b <= 1'b0;
      wait_cyc(2);
      chk("reset state", 16'h0003, 16'({mode_state, primary_error_reg, high_gate_mon_en, out_stage_mon_en}));
      @(posedge clk);
      rst_b <= 1'b1;
      send(OP_MODE, 11'h001, 1'b0);
      send(OP_MODE, 11'h002, 1'b0);
      chk("mode", 16'h0001, 16'(mode_state));
      end_sim();
   end
endmodule : test_driver_protection_verification
